//--- rtl/pmrb_pkg.sv
// package of constants and carriers for the phy management register bank
// assumes a single core clock domain and a 5-bit register index port
// What this block does
// - clear-on-read bits return their value, then that read zeroes them; writes ignored
// - latch-low bits hold their latched low until their register is read
// - latch-high bits hold their latched high until their register is read
// - self-clearing bits drop to zero by themselves; writing zero does nothing
// - read-only latch-high bits stay one after cause until read
// - after the read they follow the cause, falling once it is gone
// - bits kept through soft reset do not change on a software reset
// - that protection applies only to the soft-reset bit, not hardware reset
// - controller writes reserved fields as zero; reserved bits read undefined
// - read-write bits accept writes and read back their stored setting
// - readable any-write-clears bits read back; any write clears them
// - primary registers by index 0-10, 15-21, 27, 29-31 over management interface
// - advanced read-only registers only through address port 20, data port 21
// - control register bit 15 starts software reset and clears itself
// - every primary register is 16 bits wide
// - write-one-to-clear bits clear on a written one; zero leaves them
package pmrb_pkg;
	localparam int REG_W = 16;
	localparam int IDX_W = 5;
	localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
	localparam logic [4:0] IDX_PHY_ID_HIGH = 5'h02;
	localparam logic [4:0] IDX_PHY_ID_LOW = 5'h03;
	localparam logic [4:0] IDX_AN_ADVERT = 5'h04;
	localparam logic [4:0] IDX_AN_PARTNER = 5'h05;
	localparam logic [4:0] IDX_AN_EXPANSION = 5'h06;
	localparam logic [4:0] IDX_AN_NP_TX = 5'h07;
	localparam logic [4:0] IDX_AN_NP_RX = 5'h08;
	localparam logic [4:0] IDX_MS_CONTROL = 5'h09;
	localparam logic [4:0] IDX_MS_STATUS = 5'h0a;
	localparam logic [4:0] IDX_EXT_STATUS = 5'h0f;
	localparam logic [4:0] IDX_LINK_CONTROL = 5'h10;
	localparam logic [4:0] IDX_LS_MODE_CS = 5'h11;
	localparam logic [4:0] IDX_LS_SPECIAL = 5'h12;
	localparam logic [4:0] IDX_EXT_MODE_CS = 5'h13;
	localparam logic [4:0] IDX_ADV_ADDR = 5'h14;
	localparam logic [4:0] IDX_ADV_DATA = 5'h15;
	localparam logic [4:0] IDX_CS_IND = 5'h1b;
	localparam logic [4:0] IDX_EVT_FLAGS = 5'h1d;
	localparam logic [4:0] IDX_EVT_MASK = 5'h1e;
	localparam logic [4:0] IDX_SPECIAL_CS = 5'h1f;
	// control register fields
	localparam int CTL_SOFT_RESET_BIT = 15;
	localparam int CTL_LOOPBACK_BIT = 14;
	localparam int CTL_SPEED0_BIT = 13;
	localparam int CTL_AN_ENABLE_BIT = 12;
	localparam int CTL_POWER_DOWN_BIT = 11;
	localparam int CTL_ISOLATE_BIT = 10;
	localparam int CTL_AN_RESTART_BIT = 9;
	localparam int CTL_DUPLEX_BIT = 8;
	localparam logic [15:0] CTL_RW_MASK = 16'h7f00;
	// status register: fixed ability bits and the live/latched fields
	localparam logic [15:0] STAT_FIXED = 16'h7908;
	localparam int STAT_AN_DONE_BIT = 5;
	localparam int STAT_REMOTE_FAULT_BIT = 4;
	localparam int STAT_LINK_BIT = 2;
	localparam int STAT_JABBER_BIT = 1;
	localparam int STAT_EXT_CAP_BIT = 0;
	// generic read-write register reset values
	localparam logic [15:0] AN_ADVERT_RESET = 16'h01e1;
	localparam logic [15:0] GENERIC_RESET = 16'h0000;
	localparam logic [15:0] EVT_MASK_RESET = 16'h0000;
	localparam logic [15:0] ADV_ADDR_RESET = 16'h0000;
	localparam logic [15:0] RD_ZERO = 16'h0000;
	// kept-through-soft-reset bits of the special modes register
	localparam logic [15:0] SPECIAL_KEEP_MASK = 16'hffff;
	localparam logic [15:0] EXT_MODE_W1C_MASK = 16'h00ff;
	localparam int ADV_AW = 4;
	localparam int ADV_DEPTH = 16;
	// one management access, as the frame engine presents it
	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] idx;
		logic [15:0] wdata;
	} pmrb_req_s;
	// live conditions from the phy core
	typedef struct packed {
		logic link_up;
		logic an_done;
		logic remote_fault;
		logic jabber;
		logic an_page_rx;
		logic [15:0] event_src;
	} pmrb_cond_s;
endpackage : pmrb_pkg

//--- rtl/pmrb_latch_bit.sv
// one status latch bit with read-clear behaviour
// assumes the clear strobe is a single-cycle register read pulse
`timescale 1ns/100ps
`default_nettype none
module pmrb_latch_bit #(
	parameter bit LATCH_HIGH = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cause,
	input wire logic i_rd_clr,
	output logic o_value
);
	logic held_reg;
	logic active;
	logic active_prev_reg;
	// active level of the cause, inverted for a latch-low bit
	assign active = (i_cause == LATCH_HIGH);
	// idles inactive so a cause already active at reset release latches as an onset
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			active_prev_reg <= 1'b0;
		end else begin
			active_prev_reg <= active;
		end
	end
	// only the onset latches, so after a read the bit follows a lasting cause
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			held_reg <= 1'b0;
		end else if (active && !active_prev_reg) begin
			// onset in the read cycle still latches: set wins
			held_reg <= 1'b1;
		end else if (i_rd_clr) begin
			held_reg <= 1'b0;
		end
	end
	// after the read the bit follows the live cause
	assign o_value = LATCH_HIGH ? (held_reg | i_cause) : !(held_reg | !i_cause);
endmodule : pmrb_latch_bit
`default_nettype wire

//--- rtl/pmrb_adv_bank.sv
// read-only advanced register bank reached through an address port
// assumes the phy core drives live advanced values as a flat vector
`timescale 1ns/100ps
`default_nettype none
module pmrb_adv_bank #(
	parameter int AW = pmrb_pkg::ADV_AW,
	parameter int DEPTH = pmrb_pkg::ADV_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [DEPTH*16-1:0] i_adv_values,
	input wire logic [AW-1:0] i_sel,
	output logic [15:0] o_data
);
	// registered so the data port is stable for the next read
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_data <= pmrb_pkg::RD_ZERO;
		end else if (32'(i_sel) < DEPTH) begin
			o_data <= i_adv_values[i_sel*16 +: 16];
		end else begin
			o_data <= pmrb_pkg::RD_ZERO;
		end
	end
endmodule : pmrb_adv_bank
`default_nettype wire

//--- rtl/pmrb_register_bank.sv
// phy management register bank: indexed 16-bit registers
// assumes a frame engine on i_core_clk delivers one-cycle rd/wr strobes
`timescale 1ns/100ps
`default_nettype none
module pmrb_register_bank #(
	parameter int ADV_DEPTH = pmrb_pkg::ADV_DEPTH,
	parameter logic [15:0] PHY_ID_HIGH = 16'h1234, // arbitrary value
	parameter logic [15:0] PHY_ID_LOW = 16'h5670 // arbitrary value
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire pmrb_pkg::pmrb_req_s i_req,
	input wire pmrb_pkg::pmrb_cond_s i_cond,
	input wire logic [ADV_DEPTH*16-1:0] i_adv_values,
	input wire logic [15:0] i_partner_ability,
	input wire logic [15:0] i_partner_page,
	input wire logic [15:0] i_ms_status,
	output logic [15:0] o_rdata,
	output logic o_rvalid,
	output logic o_soft_reset,
	output logic [15:0] o_control,
	output logic o_an_restart
);
	localparam int AAW = $clog2(ADV_DEPTH);
	logic [15:0] ctl_reg;
	logic [15:0] advert_reg;
	logic [15:0] np_tx_reg;
	logic [15:0] ms_ctl_reg;
	logic [15:0] link_ctl_reg;
	logic [15:0] ls_mode_reg;
	logic [15:0] special_modes_reg;
	logic [15:0] ext_mode_reg;
	logic [15:0] adv_addr_reg;
	logic [15:0] cs_ind_reg;
	logic [15:0] evt_flags_reg;
	logic [15:0] evt_mask_reg;
	logic [15:0] special_cs_reg;
	logic page_rx_reg;
	logic sr_pend_reg;
	logic soft_rst;
	logic rd_stat;
	logic rd_exp;
	logic rf_val;
	logic link_val;
	logic jab_val;
	logic [15:0] adv_data;
	logic [15:0] rd_mux;
	logic [15:0] ls_mode_next;
	logic wr_ok;

	function automatic logic wr_to(input pmrb_pkg::pmrb_req_s r,
			input logic [4:0] idx);
		return r.wr && (r.idx == idx);
	endfunction : wr_to

	function automatic logic rd_of(input pmrb_pkg::pmrb_req_s r,
			input logic [4:0] idx);
		return r.rd && (r.idx == idx);
	endfunction : rd_of

	// supported index list; anything else reads zero and ignores writes
	function automatic logic idx_supported(input logic [4:0] idx);
		logic ok;
		ok = 1'b0;
		if (idx <= pmrb_pkg::IDX_MS_STATUS) begin
			ok = 1'b1;
		end else if ((idx >= pmrb_pkg::IDX_EXT_STATUS) &&
				(idx <= pmrb_pkg::IDX_ADV_DATA)) begin
			ok = 1'b1;
		end else if (idx == pmrb_pkg::IDX_CS_IND) begin
			ok = 1'b1;
		end else if (idx >= pmrb_pkg::IDX_EVT_FLAGS) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : idx_supported

	assign rd_stat = rd_of(i_req, pmrb_pkg::IDX_BASIC_STATUS);
	assign rd_exp = rd_of(i_req, pmrb_pkg::IDX_AN_EXPANSION);
	assign wr_ok = i_req.wr && idx_supported(i_req.idx);
	// soft reset runs one cycle after the bit is set
	assign soft_rst = sr_pend_reg;

	// soft reset request: self-clearing after one cycle
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sr_pend_reg <= 1'b0;
		end else begin
			sr_pend_reg <= wr_to(i_req, pmrb_pkg::IDX_BASIC_CONTROL) &&
				i_req.wdata[pmrb_pkg::CTL_SOFT_RESET_BIT];
		end
	end

	// control register
	always_ff @(posedge i_core_clk) begin
		if (i_rst || soft_rst) begin
			ctl_reg <= pmrb_pkg::GENERIC_RESET;
		end else if (wr_to(i_req, pmrb_pkg::IDX_BASIC_CONTROL)) begin
			// reserved and read-only bits dropped
			ctl_reg <= (i_req.wdata & pmrb_pkg::CTL_RW_MASK) |
				(i_req.wdata & 16'h8000);
		end else begin
			// reset and restart bits fall back by themselves
			ctl_reg[pmrb_pkg::CTL_SOFT_RESET_BIT] <= 1'b0;
			ctl_reg[pmrb_pkg::CTL_AN_RESTART_BIT] <= 1'b0;
		end
	end

	// plain read-write registers, loaded with their reset values by either reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst || soft_rst) begin
			advert_reg <= pmrb_pkg::AN_ADVERT_RESET;
			np_tx_reg <= pmrb_pkg::GENERIC_RESET;
			ms_ctl_reg <= pmrb_pkg::GENERIC_RESET;
			link_ctl_reg <= pmrb_pkg::GENERIC_RESET;
			cs_ind_reg <= pmrb_pkg::GENERIC_RESET;
			evt_mask_reg <= pmrb_pkg::EVT_MASK_RESET;
			special_cs_reg <= pmrb_pkg::GENERIC_RESET;
			adv_addr_reg <= pmrb_pkg::ADV_ADDR_RESET;
		end else if (wr_ok) begin
			if (i_req.idx == pmrb_pkg::IDX_AN_ADVERT) begin
				advert_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_AN_NP_TX) begin
				np_tx_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_MS_CONTROL) begin
				ms_ctl_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_LINK_CONTROL) begin
				link_ctl_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_CS_IND) begin
				cs_ind_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_EVT_MASK) begin
				evt_mask_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_SPECIAL_CS) begin
				special_cs_reg <= i_req.wdata;
			end else if (i_req.idx == pmrb_pkg::IDX_ADV_ADDR) begin
				adv_addr_reg <= i_req.wdata;
			end
		end
	end

	// special modes survive a software reset, only hardware reset clears
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			special_modes_reg <= pmrb_pkg::GENERIC_RESET;
		end else if (wr_to(i_req, pmrb_pkg::IDX_LS_SPECIAL)) begin
			special_modes_reg <= i_req.wdata;
		end else if (soft_rst) begin
			special_modes_reg <= special_modes_reg &
				pmrb_pkg::SPECIAL_KEEP_MASK;
		end
	end

	// mode control/status: any write clears the whole word
	always_comb begin
		ls_mode_next = ls_mode_reg;
		if (wr_to(i_req, pmrb_pkg::IDX_LS_MODE_CS)) begin
			ls_mode_next = pmrb_pkg::RD_ZERO;
		end
		if (i_cond.an_done) begin
			ls_mode_next[0] = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst || soft_rst) begin
			ls_mode_reg <= pmrb_pkg::GENERIC_RESET;
		end else begin
			ls_mode_reg <= ls_mode_next;
		end
	end

	// extended mode: low byte set by events, cleared by writing ones
	always_ff @(posedge i_core_clk) begin
		if (i_rst || soft_rst) begin
			ext_mode_reg <= pmrb_pkg::GENERIC_RESET;
		end else begin
			for (int b = 0; b < 16; b++) begin
				if (pmrb_pkg::EXT_MODE_W1C_MASK[b]) begin
					if (i_cond.event_src[b]) begin
						ext_mode_reg[b] <= 1'b1;
					end else if (wr_to(i_req, pmrb_pkg::IDX_EXT_MODE_CS)
							&& i_req.wdata[b]) begin
						ext_mode_reg[b] <= 1'b0;
					end
				end else if (wr_to(i_req, pmrb_pkg::IDX_EXT_MODE_CS)) begin
					ext_mode_reg[b] <= i_req.wdata[b];
				end
			end
		end
	end

	// event flags: clear on read, set wins, writes ignored
	always_ff @(posedge i_core_clk) begin
		if (i_rst || soft_rst) begin
			evt_flags_reg <= pmrb_pkg::GENERIC_RESET;
		end else if (rd_of(i_req, pmrb_pkg::IDX_EVT_FLAGS)) begin
			evt_flags_reg <= i_cond.event_src;
		end else begin
			evt_flags_reg <= evt_flags_reg | i_cond.event_src;
		end
	end

	// page received flag in expansion register is clear on read
	always_ff @(posedge i_core_clk) begin
		if (i_rst || soft_rst) begin
			page_rx_reg <= 1'b0;
		end else if (i_cond.an_page_rx) begin
			page_rx_reg <= 1'b1;
		end else if (rd_exp) begin
			page_rx_reg <= 1'b0;
		end
	end

	pmrb_latch_bit #(
		.LATCH_HIGH(1'b1)
	) u_remote_fault (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst || soft_rst),
		.i_cause(i_cond.remote_fault),
		.i_rd_clr(rd_stat),
		.o_value(rf_val)
	);

	pmrb_latch_bit #(
		.LATCH_HIGH(1'b1)
	) u_jabber (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst || soft_rst),
		.i_cause(i_cond.jabber),
		.i_rd_clr(rd_stat),
		.o_value(jab_val)
	);

	// link down events must not be missed between polls
	pmrb_latch_bit #(
		.LATCH_HIGH(1'b0)
	) u_link (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst || soft_rst),
		.i_cause(i_cond.link_up),
		.i_rd_clr(rd_stat),
		.o_value(link_val)
	);

	pmrb_adv_bank #(
		.AW(AAW),
		.DEPTH(ADV_DEPTH)
	) u_adv (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_adv_values(i_adv_values),
		.i_sel(adv_addr_reg[AAW-1:0]),
		.o_data(adv_data)
	);

	// read decode; unsupported indexes read zero
	always_comb begin
		rd_mux = pmrb_pkg::RD_ZERO;
		if (i_req.idx == pmrb_pkg::IDX_BASIC_CONTROL) begin
			rd_mux = ctl_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_BASIC_STATUS) begin
			rd_mux = pmrb_pkg::STAT_FIXED;
			rd_mux[pmrb_pkg::STAT_AN_DONE_BIT] = i_cond.an_done;
			rd_mux[pmrb_pkg::STAT_REMOTE_FAULT_BIT] = rf_val;
			rd_mux[pmrb_pkg::STAT_LINK_BIT] = link_val;
			rd_mux[pmrb_pkg::STAT_JABBER_BIT] = jab_val;
			rd_mux[pmrb_pkg::STAT_EXT_CAP_BIT] = 1'b1;
		end else if (i_req.idx == pmrb_pkg::IDX_PHY_ID_HIGH) begin
			rd_mux = PHY_ID_HIGH;
		end else if (i_req.idx == pmrb_pkg::IDX_PHY_ID_LOW) begin
			rd_mux = PHY_ID_LOW;
		end else if (i_req.idx == pmrb_pkg::IDX_AN_ADVERT) begin
			rd_mux = advert_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_AN_PARTNER) begin
			rd_mux = i_partner_ability;
		end else if (i_req.idx == pmrb_pkg::IDX_AN_EXPANSION) begin
			rd_mux = {14'h0000, page_rx_reg, 1'b1};
		end else if (i_req.idx == pmrb_pkg::IDX_AN_NP_TX) begin
			rd_mux = np_tx_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_AN_NP_RX) begin
			rd_mux = i_partner_page;
		end else if (i_req.idx == pmrb_pkg::IDX_MS_CONTROL) begin
			rd_mux = ms_ctl_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_MS_STATUS) begin
			rd_mux = i_ms_status;
		end else if (i_req.idx == pmrb_pkg::IDX_EXT_STATUS) begin
			rd_mux = 16'h3000;
		end else if (i_req.idx == pmrb_pkg::IDX_LINK_CONTROL) begin
			rd_mux = link_ctl_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_LS_MODE_CS) begin
			rd_mux = ls_mode_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_LS_SPECIAL) begin
			rd_mux = special_modes_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_EXT_MODE_CS) begin
			rd_mux = ext_mode_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_ADV_ADDR) begin
			rd_mux = adv_addr_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_ADV_DATA) begin
			rd_mux = adv_data;
		end else if (i_req.idx == pmrb_pkg::IDX_CS_IND) begin
			rd_mux = cs_ind_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_EVT_FLAGS) begin
			rd_mux = evt_flags_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_EVT_MASK) begin
			rd_mux = evt_mask_reg;
		end else if (i_req.idx == pmrb_pkg::IDX_SPECIAL_CS) begin
			rd_mux = special_cs_reg;
		end
	end

	// read answer registered one cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rdata <= pmrb_pkg::RD_ZERO;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			if (i_req.rd) begin
				o_rdata <= rd_mux;
			end
		end
	end

	// core-facing controls
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_soft_reset <= 1'b0;
			o_control <= pmrb_pkg::GENERIC_RESET;
			o_an_restart <= 1'b0;
		end else begin
			o_soft_reset <= soft_rst;
			o_control <= ctl_reg;
			o_an_restart <= ctl_reg[pmrb_pkg::CTL_AN_RESTART_BIT];
		end
	end
endmodule : pmrb_register_bank
`default_nettype wire

//--- verif/pmrb_mgmt_ctl.sv
// management controller model: one-cycle read and write strobes
// assumes the bank raises i_rvalid one cycle after a read strobe
`timescale 1ns/100ps
`default_nettype none
module pmrb_mgmt_ctl (
	input wire logic i_core_clk,
	input wire logic i_rvalid,
	input wire logic [15:0] i_rdata,
	output var pmrb_pkg::pmrb_req_s o_req
);
	initial o_req = '0;
	// bench picks the index; unsupported ones only to test refusal
	task automatic go(input logic w, input logic [4:0] i,
		input logic [15:0] d);
		@(posedge i_core_clk);
		#1 o_req = {~w, w, i, d};
		@(posedge i_core_clk);
		#1 o_req.rd = 1'b0;
		o_req.wr = 1'b0;
		// released data shows no stale value
		o_req.wdata = ~o_req.wdata;
	endtask : go
	task automatic rd(input logic [4:0] i, output logic [15:0] d,
		output logic ok);
		ok = 1'b0;
		d = 'x;
		go(1'b0, i, 16'h0000);
		for (int n = 0; n < 4 && !ok; n++) begin
			if (i_rvalid) begin
				ok = 1'b1;
				d = i_rdata;
			end else begin
				@(posedge i_core_clk);
				#1;
			end
		end
	endtask : rd
endmodule : pmrb_mgmt_ctl
`default_nettype wire

//--- verif/pmrb_register_bank_sva.sv
// port checker for the management register bank
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module pmrb_bank_sva (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire pmrb_pkg::pmrb_req_s i_req,
	input wire pmrb_pkg::pmrb_cond_s i_cond,
	input wire logic [15:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_soft_reset,
	input wire logic [15:0] o_control,
	input wire logic o_an_restart
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	logic rd_st;
	logic rd_ev;
	logic unsup;
	assign rd_st = i_req.rd && i_req.idx == 5'h01;
	assign rd_ev = i_req.rd && i_req.idx == 5'h1d && i_cond.event_src == '0;
	assign unsup = i_req.idx inside {[5'h0b:5'h0e], [5'h16:5'h1a], 5'h1c};
	sequence s_rf_then_read;
		$rose(i_cond.remote_fault) && !rd_st ##1 !rd_st ##1 rd_st;
	endsequence
	sequence s_down_then_read;
		$fell(i_cond.link_up) && !rd_st ##1 !rd_st ##1 rd_st;
	endsequence
	sequence s_two_reads;
		rd_ev ##1 (!i_req.wr && i_cond.event_src == '0) ##1 rd_ev;
	endsequence
	property p_rvalid;
		i_req.rd |=> o_rvalid;
	endproperty
	property p_rvalid_src;
		o_rvalid |-> $past(i_req.rd);
	endproperty
	property p_unsup;
		i_req.rd && unsup |=> o_rdata == 16'h0000;
	endproperty
	property p_fixed;
		rd_st |=> o_rdata[15:8] == pmrb_pkg::STAT_FIXED[15:8];
	endproperty
	property p_soft;
		i_req.wr && i_req.idx == 5'h00 && i_req.wdata[15] |-> ##[1:3] o_soft_reset;
	endproperty
	property p_selfclr;
		o_control[15] |-> ##[1:3] !o_control[15];
	endproperty
	property p_restart;
		o_an_restart |=> !o_an_restart;
	endproperty
	property p_latch_hi;
		s_rf_then_read |=> o_rdata[4];
	endproperty
	property p_latch_lo;
		s_down_then_read |=> !o_rdata[2];
	endproperty
	property p_rd_clear;
		s_two_reads |=> !o_rdata[0];
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("no read answer");
	a_rvalid_src: assert property (p_rvalid_src) else $error("stray answer");
	a_unsup: assert property (p_unsup) else $error("unsupported nonzero");
	a_fixed: assert property (p_fixed) else $error("status width bits");
	a_soft: assert property (p_soft) else $error("no soft reset");
	a_selfclr: assert property (p_selfclr) else $error("bit stuck");
	a_restart: assert property (p_restart) else $error("restart stuck");
	a_latch_hi: assert property (p_latch_hi) else $error("fault lost");
	a_latch_lo: assert property (p_latch_lo) else $error("link low lost");
	a_rd_clear: assert property (p_rd_clear) else $error("not cleared");
endmodule : pmrb_bank_sva
bind pmrb_register_bank pmrb_bank_sva u_sva (.i_core_clk(i_core_clk),
	.i_rst(i_rst), .i_req(i_req), .i_cond(i_cond), .o_rdata(o_rdata),
	.o_rvalid(o_rvalid), .o_soft_reset(o_soft_reset), .o_control(o_control),
	.o_an_restart(o_an_restart));
`default_nettype wire

//--- verif/pmrb_register_bank_tb.sv
// self-checking bench for the management register bank
// assumes the controller model in pmrb_mgmt_ctl drives every request
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("wrong value %s exp %h got %h", n, e, g); \
	end \
end
module pmrb_register_bank_tb;
	localparam logic [20:0] C_LINK = 21'h100000;
	localparam logic [20:0] C_AN = 21'h080000;
	localparam logic [20:0] C_RF = 21'h040000;
	localparam logic [20:0] C_JAB = 21'h020000;
	localparam logic [20:0] C_EV0 = 21'h000001;
	localparam logic [20:0] C_PG = 21'h010000;
	logic clk;
	logic rst;
	pmrb_pkg::pmrb_req_s req;
	pmrb_pkg::pmrb_cond_s cond;
	logic [255:0] adv;
	logic [15:0] rdata;
	logic rvalid;
	logic soft_rst;
	logic [15:0] ctl_out;
	logic an_rst;
	int err_total;
	int total_checks;
	// id values are arbitrary
	pmrb_register_bank #(.PHY_ID_HIGH(16'h2bcd), .PHY_ID_LOW(16'h9e10)) dut (
		.i_core_clk(clk), .i_rst(rst), .i_req(req), .i_cond(cond),
		.i_adv_values(adv), .i_partner_ability(16'h0000),
		.i_partner_page(16'h0000), .i_ms_status(16'h0000),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_soft_reset(soft_rst),
		.o_control(ctl_out), .o_an_restart(an_rst));
	pmrb_mgmt_ctl mgmt (.i_core_clk(clk), .i_rvalid(rvalid),
		.i_rdata(rdata), .o_req(req));
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [4:0] i, input logic [15:0] d);
		mgmt.go(1'b1, i, d);
	endtask : wr
	task automatic rd(input logic [4:0] i, output logic [15:0] d);
		logic ok;
		mgmt.rd(i, d, ok);
		if (!ok) begin
			err_total++;
			wrap_up();
		end
	endtask : rd
	task automatic rc(input string n, input logic [4:0] i,
		input logic [15:0] m, input logic [15:0] e);
		logic [15:0] d;
		rd(i, d);
		`CHK(n, e, d & m)
	endtask : rc
	// flips the chosen causes for exactly one cycle
	task automatic pulse(input logic [20:0] on);
		@(posedge clk);
		#1 cond = cond ^ on;
		@(posedge clk);
		#1 cond = cond ^ on;
	endtask : pulse
	task automatic hard_rst;
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
	endtask : hard_rst
	task automatic t_basic;
		rc("advert", 5'h04, 16'hffff, pmrb_pkg::AN_ADVERT_RESET);
		rc("id high", 5'h02, 16'hffff, 16'h2bcd);
		wr(5'h03, 16'h0000);
		rc("id low ro", 5'h03, 16'hffff, 16'h9e10);
		rc("ext status", 5'h0f, 16'hffff, 16'h3000);
		wr(5'h0c, 16'hffff);
		rc("unsupported", 5'h0c, 16'hffff, 16'h0000);
		rc("unsupported top", 5'h1c, 16'hffff, 16'h0000);
		wr(5'h1e, 16'ha5a5);
		rc("mask rw", 5'h1e, 16'hffff, 16'ha5a5);
		wr(5'h1e, 16'h5a5a);
		rc("mask rw again", 5'h1e, 16'hffff, 16'h5a5a);
	endtask : t_basic
	task automatic t_latch;
		logic [15:0] d;
		rd(5'h01, d);
		pulse(C_LINK);
		rc("link low held", 5'h01, 16'h0004, 16'h0000);
		rc("link after read", 5'h01, 16'h0004, 16'h0004);
		pulse(C_JAB);
		rc("jabber held", 5'h01, 16'h0002, 16'h0002);
		rc("jabber cleared", 5'h01, 16'h0002, 16'h0000);
		pulse(C_RF);
		rc("fault held", 5'h01, 16'h0010, 16'h0010);
		cond.remote_fault = 1'b1;
		rc("fault live", 5'h01, 16'h0010, 16'h0010);
		rc("fault live again", 5'h01, 16'h0010, 16'h0010);
		cond.remote_fault = 1'b0;
		rc("fault gone", 5'h01, 16'h0010, 16'h0000);
	endtask : t_latch
	task automatic t_events;
		pulse(C_EV0);
		wr(5'h1d, 16'h0000);
		rc("event held", 5'h1d, 16'h0001, 16'h0001);
		rc("event cleared", 5'h1d, 16'h0001, 16'h0000);
		rc("w1c held", 5'h13, 16'h0001, 16'h0001);
		wr(5'h13, 16'h0000);
		rc("w1c zero", 5'h13, 16'h0001, 16'h0001);
		wr(5'h13, 16'h0001);
		rc("w1c one", 5'h13, 16'h0001, 16'h0000);
		pulse(C_AN);
		rc("awc set", 5'h11, 16'h0001, 16'h0001);
		rc("awc reread", 5'h11, 16'h0001, 16'h0001);
		wr(5'h11, 16'h0000);
		rc("awc cleared", 5'h11, 16'h0001, 16'h0000);
		pulse(C_PG);
		rc("page held", 5'h06, 16'h0002, 16'h0002);
		rc("page cleared", 5'h06, 16'h0002, 16'h0000);
	endtask : t_events
	task automatic t_ctl;
		logic seen;
		wr(5'h00, 16'h4100);
		@(posedge clk);
		#1;
		`CHK("control out", 16'h4100, ctl_out)
		rc("control rw", 5'h00, 16'hffff, 16'h4100);
		wr(5'h00, 16'h0200);
		seen = 1'b0;
		for (int n = 0; n < 4 && !seen; n++) begin
			seen = an_rst;
			@(posedge clk);
			#1;
		end
		`CHK("restart pulse", 1'b1, seen)
		`CHK("restart drop", 1'b0, an_rst)
		rc("restart clear", 5'h00, 16'h0200, 16'h0000);
	endtask : t_ctl
	task automatic t_adv;
		wr(5'h14, 16'h0007);
		rc("adv word 7", 5'h15, 16'hffff, 16'ha007);
		wr(5'h14, 16'h000f);
		wr(5'h15, 16'h0000);
		rc("adv word 15", 5'h15, 16'hffff, 16'ha00f);
	endtask : t_adv
	task automatic t_soft;
		logic seen;
		logic [15:0] d;
		wr(5'h12, 16'hbeef);
		wr(5'h1e, 16'h1234);
		wr(5'h14, 16'h0005);
		wr(5'h00, 16'h8000);
		seen = 1'b0;
		for (int n = 0; n < 4 && !seen; n++) begin
			seen = soft_rst;
			@(posedge clk);
			#1;
		end
		`CHK("soft pulse", 1'b1, seen)
		if (!seen) wrap_up();
		rc("self clear", 5'h00, 16'h8000, 16'h0000);
		rc("mask reset", 5'h1e, 16'hffff, 16'h0000);
		rc("kept", 5'h12, 16'hffff, 16'hbeef);
		rc("addr reset", 5'h14, 16'h000f, 16'h0000);
		hard_rst();
		rd(5'h12, d);
		`CHK("hard reset", 16'h0000, d)
	endtask : t_soft
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		cond = '0;
		cond.link_up = 1'b1;
		err_total = 0;
		total_checks = 0;
		for (int n = 0; n < 16; n++) begin
			adv[n*16 +: 16] = 16'ha000 + 16'(n);
		end
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		t_basic();
		t_latch();
		t_events();
		t_adv();
		t_ctl();
		t_soft();
		wrap_up();
	end
endmodule : pmrb_register_bank_tb
`default_nettype wire
